//--- reset_source_pkg.sv
// Constants, register map and state types for the reset source controller.
// Assumes a 50 MHz system clock and a word-addressed register bus.
package reset_source_pkg;

	// Clock rate and clock-loss timeout.
	localparam int unsigned MCLK_HZ           = 50_000_000;
	localparam int unsigned CLK_LOSS_US       = 100;
	localparam int unsigned CLK_LOSS_CYCLES   = CLK_LOSS_US * (MCLK_HZ / 1_000_000);

	// Register indices; the bus address is the word index.
	localparam logic [7:0]  MON_CTRL_IDX      = 8'hFF;
	localparam logic [7:0]  SRC_IDX           = 8'hEF;

	// Monitor control register fields.
	localparam int unsigned MON_EN_BIT        = 7;
	localparam int unsigned SUPPLY_BIT        = 6;
	localparam logic        MON_EN_RESET      = 1'b1;

	// Reset source register fields.
	localparam int unsigned PIN_BIT           = 0;
	localparam int unsigned PWR_BIT           = 1;
	localparam int unsigned LOSS_BIT          = 2;
	localparam int unsigned WDOG_BIT          = 3;
	localparam int unsigned SOFT_BIT          = 4;
	localparam int unsigned COMP_BIT          = 5;
	localparam int unsigned FLASH_BIT         = 6;
	localparam logic [6:0]  FLAGS_RESET       = 7'h02;
	localparam logic [6:0]  FLAGS_WRITABLE    = 7'h26;
	localparam logic [6:0]  INTERNAL_CAUSES   = 7'h7C;

	// Highest legal user code address.
	localparam logic [15:0] CODE_LIMIT        = 16'h3DFF;

	// Reset stretch and pin blanking after release, in cycles.
	localparam logic [7:0]  HOLD_CYCLES       = 8'h10;
	localparam logic [7:0]  SETTLE_CYCLES     = 8'h04;

	// Synchroniser idle levels: pin high, supply good, comparator not low, clock low.
	localparam logic [3:0]  SYNC_RESET        = 4'h3;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_HOLD,
		ST_SETTLE
	} ctrl_state_t;

endpackage

//--- sync_if.sv
// Carries raw asynchronous levels to the input filter and clean levels back.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface sync_if #(parameter int W = 4);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport owner  (output raw, input clean);
	modport filter (input raw, output clean);
endinterface

//--- input_filter.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes inputs may change at any time relative to mclk.
`timescale 1ns/10ps
module input_filter #(
	parameter int              W       = 4,
	parameter logic [W-1:0]    INIT    = '0
) (
	// Clock and reset.
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	// Raw in, filtered out.
	sync_if.filter             port
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] clean;
	} filt_state_t;

	filt_state_t q;
	filt_state_t d;

	// A change is accepted once stages two and three agree.
	always_comb begin
		d = q;
		d.s1 = port.raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.clean[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= {INIT, INIT, INIT, INIT};
		end else begin
			q <= d;
		end
	end

	assign port.clean = q.clean;

endmodule

//--- reset_source_controller.sv
// Reset source controller: gathers reset causes, stretches the system reset
// and records which source caused the last one.
// Assumes sys_rst is the power-on reset and all event inputs share mclk.
`timescale 1ns/10ps
// Notes on behaviour
// (R1) Monitor enable gates supply monitor resets.
// (R2) Software lets monitor settle before selecting.
// (R3) Supply status bit shows live monitor.
// (R4) Low six monitor bits read zero.
// (R5) Low reset pin holds device reset.
// (R6) Pin reset sets pin flag on exit.
// (R7) Stuck clock over timeout forces reset.
// (R8) Clock-loss flag reads one after own reset.
// (R9) Clock-loss flag write enables the detector.
// (R10) Internal resets never drive the pin.
// (R11) Writing comparator flag enables comparator reset.
// (R12) Comparator low output holds reset.
// (R13) Software lets comparator settle before enabling.
// (R14) Comparator flag reads one after own reset.
// (R15) Watchdog overflow resets, sets watchdog flag.
// (R16) Enabled data write above limit resets.
// (R17) Code read above limit resets.
// (R18) Branch above limit resets.
// (R19) Security-blocked flash access resets.
// (R20) Flash faults set flash flag.
// (R21) Software flag write forces reset, reads one.
// (R22) Power flag on power resets, cleared otherwise.
// (R23) Only the causing flag reads one after reset.
module reset_source_controller #(
	parameter int unsigned          LOSS_CYCLES = reset_source_pkg::CLK_LOSS_CYCLES
) (
	// Clock and reset.
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	// Avalon-MM register slave.
	input  wire logic [7:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	// External reset pin, split into its three signals.
	input  wire logic               rstPinInN,
	output logic                    rstPinOut,
	output logic                    rstPinOeN,
	// Asynchronous analog and clock status inputs.
	input  wire logic               supplyAboveIn,
	input  wire logic               compBelowIn,
	input  wire logic               coreClkIn,
	// Same-clock event inputs.
	input  wire logic               watchdogOverflow,
	input  wire logic               flashWriteEnable,
	input  wire logic               extWriteValid,
	input  wire logic [15:0]        extWriteAddr,
	input  wire logic               codeReadValid,
	input  wire logic [15:0]        codeReadAddr,
	input  wire logic               branchValid,
	input  wire logic [15:0]        branchAddr,
	input  wire logic               securityBlock,
	// System reset to the rest of the device.
	output logic                    systemReset
);
	import reset_source_pkg::*;

	typedef struct packed {
		ctrl_state_t  st;
		logic [7:0]   cnt;
		logic [6:0]   flags;
		logic [6:0]   cause;
		logic         monEn;
		logic         swReq;
		logic         waitReq;
		logic [7:0]   rdData;
		logic         sysRst;
		logic         pinOeN;
		logic         pinOut;
		logic         clkPrev;
		logic [31:0]  lossCnt;
	} ctrl_t;

	ctrl_t q;
	ctrl_t d;

	sync_if #(.W(4)) syn ();

	input_filter #(
		.W    (4),
		.INIT (SYNC_RESET)
	) u_filter (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.port    (syn)
	);

	assign syn.raw = {coreClkIn, compBelowIn, supplyAboveIn, rstPinInN};

	logic        pinLow;
	logic        supplyAbove;
	logic        compBelow;
	logic        coreClk;
	logic        flashFault;
	logic        lossTrip;
	logic        levelHold;
	logic [6:0]  trig;
	logic        busAck;

	assign pinLow      = !syn.clean[0];
	assign supplyAbove = syn.clean[1];
	assign compBelow   = syn.clean[2];
	assign coreClk     = syn.clean[3];

	function automatic logic aboveCode(input logic [15:0] addr);
		return addr > CODE_LIMIT;
	endfunction

	// Keeps the highest-priority cause only, power first, then pin.
	function automatic logic [6:0] pickCause(input logic [6:0] t);
		logic [6:0] r;
		r = '0;
		if (t[PWR_BIT]) begin
			r[PWR_BIT] = 1'b1;
		end else if (t[PIN_BIT]) begin
			r[PIN_BIT] = 1'b1;
		end else begin
			for (int i = 6; i >= 2; i--) begin
				if (t[i] && r == '0) begin
					r[i] = 1'b1;
				end
			end
		end
		return r;
	endfunction

	// (R16) (R17) (R18) (R19) flash fault sources.
	assign flashFault = (flashWriteEnable && extWriteValid && aboveCode(extWriteAddr))
		|| (codeReadValid && aboveCode(codeReadAddr))
		|| (branchValid && aboveCode(branchAddr))
		|| securityBlock;

	// (R7) clock stuck past timeout.
	assign lossTrip = q.flags[LOSS_BIT] && (q.lossCnt >= LOSS_CYCLES);

	// (R1) (R12) level sources hold reset.
	// A pin that the device itself pulls low does not stretch its own reset.
	assign levelHold = (pinLow && q.pinOeN)
		|| (q.flags[COMP_BIT] && compBelow)
		|| (q.monEn && q.flags[PWR_BIT] && !supplyAbove);

	always_comb begin
		trig = '0;
		trig[PIN_BIT]   = pinLow;
		trig[PWR_BIT]   = q.monEn && q.flags[PWR_BIT] && !supplyAbove;
		trig[LOSS_BIT]  = lossTrip;
		trig[WDOG_BIT]  = watchdogOverflow;
		trig[SOFT_BIT]  = q.swReq;
		trig[COMP_BIT]  = q.flags[COMP_BIT] && compBelow;
		trig[FLASH_BIT] = flashFault;
	end

	assign busAck = !q.waitReq && (avs_read || avs_write);

	always_comb begin
		d = q;
		d.pinOut = 1'b0;
		d.swReq = 1'b0;
		// Bus: wait one cycle, then answer with waitrequest low for one cycle.
		if (busAck) begin
			d.waitReq = 1'b1;
		end else if (avs_read || avs_write) begin
			d.waitReq = 1'b0;
			d.rdData = '0;
			if (avs_address == MON_CTRL_IDX) begin
				// (R3) (R4) live status, low bits zero.
				d.rdData[MON_EN_BIT] = q.monEn;
				d.rdData[SUPPLY_BIT] = supplyAbove;
			end else if (avs_address == SRC_IDX) begin
				d.rdData = {1'b0, q.flags};
			end
		end
		if (busAck && avs_write) begin
			if (avs_address == MON_CTRL_IDX) begin
				d.monEn = avs_writedata[MON_EN_BIT];
			end else if (avs_address == SRC_IDX) begin
				// (R9) (R11) enable bits take the written value.
				d.flags = (q.flags & ~FLAGS_WRITABLE) | (avs_writedata[6:0] & FLAGS_WRITABLE);
				// (R21) forcing write.
				d.swReq = avs_writedata[SOFT_BIT];
			end
		end
		// Clock-loss counter restarts on each edge of the watched clock.
		d.clkPrev = coreClk;
		if (!q.flags[LOSS_BIT] || coreClk != q.clkPrev || q.st != ST_RUN) begin
			d.lossCnt = '0;
		end else if (!lossTrip) begin
			d.lossCnt = q.lossCnt + 32'h0000_0001;
		end
		case (q.st)
			ST_RUN: begin
				if (trig != '0) begin
					d.st = ST_HOLD;
					d.cause = pickCause(trig);
					d.cnt = HOLD_CYCLES;
					d.sysRst = 1'b1;
					// (R10) only supply resets drive the pin.
					d.pinOeN = !trig[PWR_BIT];
				end
			end
			ST_HOLD: begin
				// (R5) pin low keeps the device held.
				if (levelHold) begin
					d.cnt = HOLD_CYCLES;
				end else if (q.cnt != '0) begin
					d.cnt = q.cnt - 8'h01;
				end else begin
					d.st = ST_SETTLE;
					d.cnt = SETTLE_CYCLES;
					d.sysRst = 1'b0;
					d.pinOeN = 1'b1;
					// (R6) (R8) (R14) (R15) (R20) (R21) (R22) (R23) latch cause on exit.
					d.flags = q.cause;
				end
			end
			ST_SETTLE: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 8'h01;
				end else begin
					d.st = ST_RUN;
				end
			end
			default: begin
				d.st = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			q.st      <= ST_RUN;
			q.cnt     <= '0;
			q.flags   <= FLAGS_RESET;
			q.cause   <= FLAGS_RESET;
			q.monEn   <= MON_EN_RESET;
			q.swReq   <= 1'b0;
			q.waitReq <= 1'b1;
			q.rdData  <= '0;
			q.sysRst  <= 1'b0;
			q.pinOeN  <= 1'b1;
			q.pinOut  <= 1'b0;
			q.clkPrev <= 1'b0;
			q.lossCnt <= '0;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata    = {24'h00_0000, q.rdData};
	assign avs_waitrequest = q.waitReq;
	assign rstPinOut       = q.pinOut;
	assign rstPinOeN       = q.pinOeN;
	assign systemReset     = q.sysRst;

	chk_mon_gate: assert property (@(posedge mclk) disable iff (sys_rst) // R1
		($rose(q.sysRst) && q.cause[PWR_BIT]) |-> $past(q.monEn && q.flags[PWR_BIT]))
		else $error("Supply reset without monitor enabled and selected.");

	chk_status_live: assert property (@(posedge mclk) disable iff (sys_rst) // R3
		(!q.waitReq && $past(q.waitReq) && avs_read && avs_address == MON_CTRL_IDX)
		|-> avs_readdata[SUPPLY_BIT] == $past(supplyAbove))
		else $error("Supply status bit does not follow the monitor.");

	chk_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst) // R4
		(!q.waitReq && avs_read && avs_address == MON_CTRL_IDX) |-> avs_readdata[5:0] == 6'h00)
		else $error("Reserved monitor bits not zero.");

	chk_pin_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R5
		(q.st == ST_HOLD && pinLow && q.pinOeN) |=> (q.sysRst && q.st == ST_HOLD))
		else $error("Reset released while pin low.");

	chk_pin_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		($fell(q.sysRst) && q.cause[PIN_BIT]) |-> q.flags[PIN_BIT])
		else $error("Pin flag not set after pin reset.");

	chk_loss_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		(q.st == ST_RUN && lossTrip) |=> q.sysRst)
		else $error("Clock loss did not reset.");

	chk_no_pin_drive: assert property (@(posedge mclk) disable iff (sys_rst) // R10
		(q.sysRst && (q.cause & INTERNAL_CAUSES) != '0) |-> q.pinOeN)
		else $error("Internal reset drove the pin.");

	chk_flash_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R19
		(q.st == ST_RUN && flashFault) |=> (q.sysRst && q.cause != '0))
		else $error("Flash fault did not reset.");

	chk_soft_force: assert property (@(posedge mclk) disable iff (sys_rst) // R21
		(busAck && avs_write && avs_address == SRC_IDX && avs_writedata[SOFT_BIT]
			&& q.st == ST_RUN && trig == '0) |-> ##2 q.sysRst)
		else $error("Software force did not reset.");

	chk_cause_latch: assert property (@(posedge mclk) disable iff (sys_rst) // R23
		$fell(q.sysRst) |-> (q.flags == q.cause && $countones(q.flags) == 1))
		else $error("Flags do not show a single cause after reset.");

	chk_loss_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R8
		($fell(q.sysRst) && q.cause[LOSS_BIT]) |-> q.flags[LOSS_BIT])
		else $error("Clock-loss flag not set after clock-loss reset.");

	chk_loss_off: assert property (@(posedge mclk) disable iff (sys_rst) // R9
		!q.flags[LOSS_BIT] |=> (q.lossCnt == 32'h0000_0000))
		else $error("Clock-loss counter runs while disabled.");

	chk_pin_owner: assert property (@(posedge mclk) disable iff (sys_rst) // R10
		!q.pinOeN |-> (q.sysRst && q.cause[PWR_BIT]))
		else $error("Pin driven outside a supply reset.");

	chk_comp_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R11
		(q.st == ST_RUN && q.flags[COMP_BIT] && compBelow) |=> q.sysRst)
		else $error("Enabled comparator did not reset.");

	chk_comp_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R12
		(q.st == ST_HOLD && q.flags[COMP_BIT] && compBelow) |=> (q.sysRst && q.st == ST_HOLD))
		else $error("Reset released while comparator low.");

	chk_comp_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R14
		($fell(q.sysRst) && q.cause[COMP_BIT]) |-> q.flags[COMP_BIT])
		else $error("Comparator flag not set after comparator reset.");

	chk_wdog_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R15
		($fell(q.sysRst) && q.cause[WDOG_BIT]) |-> q.flags[WDOG_BIT])
		else $error("Watchdog flag not set after watchdog reset.");

	chk_flash_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R20
		($fell(q.sysRst) && q.cause[FLASH_BIT]) |-> q.flags[FLASH_BIT])
		else $error("Flash flag not set after flash fault reset.");

	chk_soft_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R21
		($fell(q.sysRst) && q.cause[SOFT_BIT]) |-> q.flags[SOFT_BIT])
		else $error("Software flag not set after forced reset.");

	chk_power_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R22
		($fell(q.sysRst) && q.cause[PWR_BIT]) |-> q.flags[PWR_BIT])
		else $error("Power flag not set after supply reset.");

endmodule

//--- rst_pin_driver.sv
// Model of the external reset circuitry: pulls the reset pin low on request.
// Assumes an external pull-up holds the pin high whenever it is released.
`timescale 1ns/10ps
module rst_pin_driver (
	// Clock.
	input  wire logic       mclk,
	// Press request and its length in cycles.
	input  wire logic       press,
	input  wire logic [7:0] pressLen,
	// Open-drain pull, low while pressed.
	output logic            pullLowN
);
	logic [7:0] left;

	initial begin
		left = 8'h00;
		pullLowN = 1'b1;
	end

	// The pin is released to the pull-up once the press has run out.
	always @(posedge mclk) begin
		if (press) begin
			left <= pressLen;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
		pullLowN <= !(press || left > 8'h01);
	end
endmodule

//--- reset_source_controller_tb.sv
// Self-checking testbench for the reset source controller.
// Assumes the design package and the pin driver model are compiled first.
`timescale 1ns/10ps
module reset_source_controller_tb;
	import reset_source_pkg::*;
	logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic        rstPinInN, rstPinOut, rstPinOeN, supplyAboveIn, compBelowIn;
	logic        coreClkIn, watchdogOverflow, flashWriteEnable, systemReset;
	logic        extWriteValid, codeReadValid, branchValid, securityBlock;
	logic [15:0] extWriteAddr, codeReadAddr, branchAddr;
	logic        press, pullLowN, clkRun;
	logic [1:0]  clkDiv;
	logic [7:0]  pressLen;
	int          errTotal, nTests;

	reset_source_controller #(.LOSS_CYCLES(20)) dut (.mclk(mclk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rstPinInN(rstPinInN), .rstPinOut(rstPinOut),
		.rstPinOeN(rstPinOeN), .supplyAboveIn(supplyAboveIn), .compBelowIn(compBelowIn),
		.coreClkIn(coreClkIn), .watchdogOverflow(watchdogOverflow),
		.flashWriteEnable(flashWriteEnable), .extWriteValid(extWriteValid),
		.extWriteAddr(extWriteAddr), .codeReadValid(codeReadValid),
		.codeReadAddr(codeReadAddr), .branchValid(branchValid), .branchAddr(branchAddr),
		.securityBlock(securityBlock), .systemReset(systemReset));
	rst_pin_driver ext (.mclk(mclk), .press(press), .pressLen(pressLen), .pullLowN(pullLowN));

	// Pin level from the pull-up, the external pull and the device drive.
	assign rstPinInN = pullLowN & (rstPinOeN | rstPinOut);
	always #10 mclk = ~mclk;
	// The watched clock runs at a quarter of mclk so the input filter can follow it.
	always @(posedge mclk) if (clkRun) clkDiv <= clkDiv + 2'h1;
	assign coreClkIn = clkDiv[1];

	task giveVerdict;
		$display("compared %0d, mismatched %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task hang;
		errTotal++;
		giveVerdict;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		i = 0;
		do begin @(posedge mclk); i++; end while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50) hang;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task noRst(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin @(posedge mclk); if (systemReset !== 1'b0) hit = 1'b1; end
		chk(hit, 1'b0);
	endtask
	task waitRst(input logic [7:0] exp, input logic pinExp);
		int i;
		logic oeLow;
		oeLow = 1'b0;
		for (i = 0; systemReset !== 1'b1; i++) begin if (i > 99) hang; @(posedge mclk); end
		for (i = 0; systemReset !== 1'b0; i++) begin
			if (i > 299) hang;
			if (rstPinOeN === 1'b0) oeLow = 1'b1;
			@(posedge mclk);
		end
		repeat (8) @(posedge mclk);
		bus(1'b0, SRC_IDX, 8'h00);
		chk(rd, {24'h0, exp});
		chk(oeLow, pinExp);
	endtask
	task kick(input int k, input logic [15:0] a);
		{extWriteAddr, codeReadAddr, branchAddr} <= {a, a, a};
		{extWriteValid, codeReadValid, branchValid} <= {k == 0, k == 1, k == 2};
		{securityBlock, watchdogOverflow} <= {k == 3, k == 4};
		@(posedge mclk);
		{extWriteValid, codeReadValid, branchValid, securityBlock, watchdogOverflow} <= '0;
		@(posedge mclk);
	endtask

	task testRegs;
		bus(1'b0, MON_CTRL_IDX, 8'h00);
		chk(rd, 32'hC0);
		bus(1'b0, SRC_IDX, 8'h00);
		chk(rd, 32'h02);
		bus(1'b0, 8'h10, 8'h00);
		chk(rd, 32'h00);
		bus(1'b1, MON_CTRL_IDX, 8'h3F);
		bus(1'b0, MON_CTRL_IDX, 8'h00);
		chk(rd, 32'h40);
		supplyAboveIn <= 1'b0;
		noRst(8);
		bus(1'b0, MON_CTRL_IDX, 8'h00);
		chk(rd, 32'h00);
		supplyAboveIn <= 1'b1;
		repeat (6) @(posedge mclk);
		bus(1'b1, MON_CTRL_IDX, 8'h80);
		noRst(8);
		$display("done: registers");
	endtask
	task testPin;
		press <= 1'b1;
		pressLen <= 8'h1E;
		@(posedge mclk);
		press <= 1'b0;
		repeat (25) @(posedge mclk);
		chk(systemReset, 1);
		waitRst(8'h01, 1'b0);
		$display("done: pin");
	endtask
	task testEvents;
		kick(4, 16'h0000);
		waitRst(8'h08, 1'b0);
		bus(1'b1, SRC_IDX, 8'h10);
		waitRst(8'h10, 1'b0);
		kick(0, 16'h3E00);
		kick(1, 16'h3DFF);
		kick(2, 16'h3DFF);
		noRst(10);
		flashWriteEnable <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			kick(k, 16'h3E00);
			waitRst(8'h40, 1'b0);
		end
		$display("done: events");
	endtask
	task testComp;
		compBelowIn <= 1'b1;
		noRst(10);
		compBelowIn <= 1'b0;
		repeat (6) @(posedge mclk);
		bus(1'b1, SRC_IDX, 8'h20);
		bus(1'b0, SRC_IDX, 8'h00);
		chk(rd & 32'h20, 32'h20);
		compBelowIn <= 1'b1;
		repeat (20) @(posedge mclk);
		chk(systemReset, 1);
		compBelowIn <= 1'b0;
		waitRst(8'h20, 1'b0);
		$display("done: comparator");
	endtask
	task testLoss;
		bus(1'b1, SRC_IDX, 8'h04);
		bus(1'b0, SRC_IDX, 8'h00);
		chk(rd & 32'h04, 32'h04);
		noRst(40);
		clkRun <= 1'b0;
		noRst(15);
		repeat (20) @(posedge mclk);
		chk(systemReset, 1);
		clkRun <= 1'b1;
		waitRst(8'h04, 1'b0);
		bus(1'b1, SRC_IDX, 8'h00);
		clkRun <= 1'b0;
		noRst(60);
		clkRun <= 1'b1;
		$display("done: clock loss");
	endtask
	task testPower;
		bus(1'b1, SRC_IDX, 8'h02);
		supplyAboveIn <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(rstPinOut, 1'b0);
		supplyAboveIn <= 1'b1;
		waitRst(8'h02, 1'b1);
		$display("done: supply monitor");
	endtask

	initial begin
		{mclk, avs_read, avs_write, press, compBelowIn, clkDiv} = '0;
		{watchdogOverflow, flashWriteEnable, extWriteValid, codeReadValid} = '0;
		{branchValid, securityBlock, errTotal, nTests} = '0;
		{avs_address, avs_writedata, pressLen} = '0;
		{extWriteAddr, codeReadAddr, branchAddr} = '0;
		{sys_rst, supplyAboveIn, clkRun} = 3'b111;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge mclk);
		testRegs;
		testPin;
		testEvents;
		testComp;
		testLoss;
		testPower;
		giveVerdict;
	end
endmodule
